// file: verilog/simsk_pkg.sv
/*
 System-control interrupt mask package: register offsets, bit positions,
 reset values, the AHB NONSEQ and SEQ transfer codes and the reserved read value.
 Assumes nothing of its surroundings; imported whole by the design modules.
*/
package simsk_pkg;
   localparam int          SIMSK_NUM_EVENTS    = 7;
   localparam logic [11:0] SIMSK_RAW_OFFSET    = 12'h050;
   localparam logic [11:0] SIMSK_MASK_OFFSET   = 12'h054;
   localparam logic [11:0] SIMSK_MISC_OFFSET   = 12'h058;
   localparam logic [11:0] SIMSK_BOCTL_OFFSET  = 12'h030;
   localparam logic [6:0]  SIMSK_MASK_RESET    = 7'h00;
   localparam logic [6:0]  SIMSK_RAW_RESET     = 7'h00;
   localparam logic        SIMSK_BOCTL_RESET   = 1'b0;
   localparam int          SIMSK_BIT_PLL_FAULT = 0;
   localparam int          SIMSK_BIT_BROWNOUT  = 1;
   localparam int          SIMSK_BIT_SUPPLY    = 2;
   localparam int          SIMSK_BIT_MAIN_OSC  = 3;
   localparam int          SIMSK_BIT_INT_OSC   = 4;
   localparam int          SIMSK_BIT_CUR_LIMIT = 5;
   localparam int          SIMSK_BIT_PLL_LOCK  = 6;
   localparam int          SIMSK_BOCTL_SEL_BIT = 1;
   localparam logic [1:0]  SIMSK_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  SIMSK_HTRANS_SEQ    = 2'h3;
   localparam logic [31:0] SIMSK_RSVD_READ     = 32'h00000000;
endpackage

// file: verilog/simsk_event_bits.sv
/*
 Raw event status bits with write-one-to-clear, one per event.
 Assumes event inputs are synchronous to CLK; set wins over clear.
*/
`timescale 1ns/1ps
module simsk_event_bits
   import simsk_pkg::*;
#(
   parameter int N = SIMSK_NUM_EVENTS
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [N-1:0] event_in,
   input  wire logic [N-1:0] clear,
   output logic      [N-1:0] raw
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               raw[i] <= 1'b0;
            end else if (ce) begin
               // Event set beats a simultaneous clear so none is lost
               raw[i] <= event_in[i] | (raw[i] & ~clear[i]); // [R10]
            end
         end
      end
   endgenerate
endmodule

// file: verilog/simsk_top.sv
/*
 System-control interrupt mask block: AHB-Lite slave with raw status,
 mask and masked-status/clear registers and one level interrupt.
 Assumes one bus master, single word transfers, events synchronous to CLK.
*/
//
// What this block does
// [R1] Mask register at 0x054, seven read/write bits, reset to zero.
// [R2] Bits 31:7 of mask are reserved, read-only, writes ignored.
// [R3] Mask bit 6 set: PLL-lock raw status raises the interrupt.
// [R4] Mask bit 5 set: current-limit raw status raises the interrupt.
// [R5] Mask bit 4 set: internal oscillator fault raises the interrupt.
// [R6] Mask bit 3 set: main oscillator fault raises the interrupt.
// [R7] Mask bit 2 set: unregulated supply raises the interrupt.
// [R8] Mask bit 1 set: brown-out raw status raises the interrupt.
// [R9] Mask bit 0 set: PLL fault raw status raises the interrupt.
// [R10] Raw bits are set by hardware regardless of the mask.
// [R11] Masked status is raw AND mask; writing one clears both.
// [R12] Brown-out interrupts only when its select bit is clear.
// [R13] Interrupt output is the OR of all masked bits, registered.
`timescale 1ns/1ps
module simsk_top
   import simsk_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        CE,
   input  wire logic        HSEL,
   input  wire logic [11:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        PLL_LOCK_EVENT,
   input  wire logic        CURRENT_LIMIT_EVENT,
   input  wire logic        INT_OSC_FAULT_EVENT,
   input  wire logic        MAIN_OSC_FAULT_EVENT,
   input  wire logic        SUPPLY_UNREG_EVENT,
   input  wire logic        BROWNOUT_EVENT,
   input  wire logic        PLL_FAULT_EVENT,
   output logic             IRQ
);
   localparam int N = SIMSK_NUM_EVENTS;
   localparam logic [N-1:0] BO_ONLY = {{(N-1){1'b0}}, 1'b1} << SIMSK_BIT_BROWNOUT;

   logic [N-1:0] interrupt_mask_register;
   logic         brownout_irq_or_reset_select;
   logic [N-1:0] raw_event_status_register;
   logic         wr_pend;
   logic [11:0]  wr_addr;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a[11:2] == off[11:2]);
   endfunction

   wire [N-1:0] event_vec = {PLL_LOCK_EVENT, CURRENT_LIMIT_EVENT, INT_OSC_FAULT_EVENT,
                             MAIN_OSC_FAULT_EVENT, SUPPLY_UNREG_EVENT, BROWNOUT_EVENT,
                             PLL_FAULT_EVENT};
   wire addr_phase = HSEL & HREADY & (HTRANS == SIMSK_HTRANS_NONSEQ | HTRANS == SIMSK_HTRANS_SEQ);
   wire rd_take    = addr_phase & ~HWRITE;
   wire wr_mask    = wr_pend & hit(wr_addr, SIMSK_MASK_OFFSET);
   wire wr_misc    = wr_pend & hit(wr_addr, SIMSK_MISC_OFFSET);
   wire wr_boctl   = wr_pend & hit(wr_addr, SIMSK_BOCTL_OFFSET);

   // Brown-out left out of the masked status and interrupt when the select bit is set
   wire [N-1:0] gate_mask = interrupt_mask_register
                          & ~({{(N-1){1'b0}}, brownout_irq_or_reset_select}
                              << SIMSK_BIT_BROWNOUT); // [R12]
   wire [N-1:0] masked = raw_event_status_register & gate_mask; // [R11]
   wire [N-1:0] clear_vec = wr_misc ? HWDATA[N-1:0] : {N{1'b0}}; // [R11]

   wire [31:0] rd_word =
      hit(HADDR, SIMSK_MASK_OFFSET)  ? {25'h0, interrupt_mask_register} : // [R2]
      hit(HADDR, SIMSK_RAW_OFFSET)   ? {25'h0, raw_event_status_register} :
      hit(HADDR, SIMSK_MISC_OFFSET)  ? {25'h0, masked} :
      hit(HADDR, SIMSK_BOCTL_OFFSET) ? {30'h0, brownout_irq_or_reset_select, 1'b0} :
      SIMSK_RSVD_READ;

   simsk_event_bits #(.N(N)) u_events (
      .clk      (CLK),
      .rst_n    (RST_N),
      .ce       (CE),
      .event_in (event_vec),
      .clear    (clear_vec),
      .raw      (raw_event_status_register)
   );

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
      end else if (CE) begin
         wr_pend <= addr_phase & HWRITE;
         wr_addr <= HADDR;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         interrupt_mask_register      <= SIMSK_MASK_RESET; // [R1]
         brownout_irq_or_reset_select <= SIMSK_BOCTL_RESET;
      end else if (CE) begin
         // Only the low seven bits are stored; reserved write data is dropped
         if (wr_mask) begin
            interrupt_mask_register <= HWDATA[N-1:0]; // [R1] [R2]
         end
         if (wr_boctl) begin
            brownout_irq_or_reset_select <= HWDATA[SIMSK_BOCTL_SEL_BIT];
         end
      end
   end

   // Read data registered in the address phase, so zero wait states both ways
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         HRDATA    <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         IRQ       <= 1'b0;
      end else if (CE) begin
         if (rd_take) begin
            HRDATA <= rd_word;
         end
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         // One cycle behind the masked status
         IRQ <= |masked; // [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R13]
      end
   end

   property p_irq_follows;
      @(posedge CLK) disable iff (!RST_N) CE |=> IRQ == $past(|masked);
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch"); // [R13]

   property p_pll_lock;
      @(posedge CLK) disable iff (!RST_N)
         CE && raw_event_status_register[SIMSK_BIT_PLL_LOCK]
            && interrupt_mask_register[SIMSK_BIT_PLL_LOCK] |=> IRQ;
   endproperty
   a_pll_lock: assert property (p_pll_lock) else $error("pll lock irq missing"); // [R3]

   property p_cur_limit;
      @(posedge CLK) disable iff (!RST_N)
         CE && raw_event_status_register[SIMSK_BIT_CUR_LIMIT]
            && interrupt_mask_register[SIMSK_BIT_CUR_LIMIT] |=> IRQ;
   endproperty
   a_cur_limit: assert property (p_cur_limit) else $error("current limit irq missing"); // [R4]

   property p_int_osc;
      @(posedge CLK) disable iff (!RST_N)
         CE && raw_event_status_register[SIMSK_BIT_INT_OSC]
            && interrupt_mask_register[SIMSK_BIT_INT_OSC] |=> IRQ;
   endproperty
   a_int_osc: assert property (p_int_osc) else $error("int osc irq missing"); // [R5]

   property p_main_osc;
      @(posedge CLK) disable iff (!RST_N)
         CE && raw_event_status_register[SIMSK_BIT_MAIN_OSC]
            && interrupt_mask_register[SIMSK_BIT_MAIN_OSC] |=> IRQ;
   endproperty
   a_main_osc: assert property (p_main_osc) else $error("main osc irq missing"); // [R6]

   property p_supply;
      @(posedge CLK) disable iff (!RST_N)
         CE && raw_event_status_register[SIMSK_BIT_SUPPLY]
            && interrupt_mask_register[SIMSK_BIT_SUPPLY] |=> IRQ;
   endproperty
   a_supply: assert property (p_supply) else $error("supply irq missing"); // [R7]

   property p_brownout;
      @(posedge CLK) disable iff (!RST_N)
         CE && raw_event_status_register[SIMSK_BIT_BROWNOUT] && !brownout_irq_or_reset_select
            && interrupt_mask_register[SIMSK_BIT_BROWNOUT] |=> IRQ;
   endproperty
   a_brownout: assert property (p_brownout) else $error("brownout irq missing"); // [R8]

   property p_pll_fault;
      @(posedge CLK) disable iff (!RST_N)
         CE && raw_event_status_register[SIMSK_BIT_PLL_FAULT]
            && interrupt_mask_register[SIMSK_BIT_PLL_FAULT] |=> IRQ;
   endproperty
   a_pll_fault: assert property (p_pll_fault) else $error("pll fault irq missing"); // [R9]

   property p_quiet_mask;
      @(posedge CLK) disable iff (!RST_N)
         CE && interrupt_mask_register == SIMSK_MASK_RESET ##1 CE |-> !IRQ;
   endproperty
   a_quiet_mask: assert property (p_quiet_mask) else $error("irq with all masked"); // [R3]

   property p_bo_select;
      @(posedge CLK) disable iff (!RST_N)
         brownout_irq_or_reset_select |-> !masked[SIMSK_BIT_BROWNOUT];
   endproperty
   a_bo_select: assert property (p_bo_select) else $error("brownout not routed"); // [R12]

   property p_event_sets;
      @(posedge CLK) disable iff (!RST_N)
         CE && (event_vec != 7'h00) |=> (raw_event_status_register & $past(event_vec))
                                          == $past(event_vec);
   endproperty
   a_event_sets: assert property (p_event_sets) else $error("raw bit not set"); // [R10]

   property p_w1c;
      @(posedge CLK) disable iff (!RST_N)
         CE && wr_misc && HWDATA[0] && !PLL_FAULT_EVENT |=> !raw_event_status_register[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear"); // [R11]

   property p_mask_write;
      @(posedge CLK) disable iff (!RST_N)
         CE && wr_mask |=> interrupt_mask_register == $past(HWDATA[6:0]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // [R1]

   // Bus steps as the slave sees them; a write lands one cycle after its address
   sequence s_mask_wr_addr;
      CE && addr_phase && HWRITE && hit(HADDR, SIMSK_MASK_OFFSET);
   endsequence

   sequence s_misc_wr_addr;
      CE && addr_phase && HWRITE && hit(HADDR, SIMSK_MISC_OFFSET);
   endsequence

   sequence s_mask_rd_addr;
      CE && rd_take && hit(HADDR, SIMSK_MASK_OFFSET);
   endsequence

   sequence s_raw_rd_addr;
      CE && rd_take && hit(HADDR, SIMSK_RAW_OFFSET);
   endsequence

   sequence s_data_phase;
      CE && wr_pend;
   endsequence

   sequence s_fault_event;
      CE && PLL_FAULT_EVENT;
   endsequence

   property p_mask_bus;
      @(posedge CLK) disable iff (!RST_N)
         s_mask_wr_addr ##1 s_data_phase
            |=> interrupt_mask_register == $past(HWDATA[N-1:0]);
   endproperty
   a_mask_bus: assert property (p_mask_bus) else $error("mask bus write lost"); // [R1]

   property p_misc_bus;
      @(posedge CLK) disable iff (!RST_N)
         s_misc_wr_addr ##1 s_data_phase
            |=> (raw_event_status_register & $past(HWDATA[N-1:0] & ~event_vec))
                == {N{1'b0}};
   endproperty
   a_misc_bus: assert property (p_misc_bus) else $error("bus clear lost"); // [R11]

   property p_mask_read;
      @(posedge CLK) disable iff (!RST_N)
         s_mask_rd_addr |=> HRDATA == {{(32-N){1'b0}}, $past(interrupt_mask_register)};
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("mask read wrong"); // [R1]

   property p_mask_rsvd;
      @(posedge CLK) disable iff (!RST_N)
         s_mask_rd_addr |=> HRDATA[31:N] == {(32-N){1'b0}};
   endproperty
   a_mask_rsvd: assert property (p_mask_rsvd) else $error("reserved bits not zero"); // [R2]

   property p_raw_read;
      @(posedge CLK) disable iff (!RST_N)
         s_raw_rd_addr |=> HRDATA == {{(32-N){1'b0}}, $past(raw_event_status_register)};
   endproperty
   a_raw_read: assert property (p_raw_read) else $error("raw read wrong"); // [R10]

   property p_mask_holds;
      @(posedge CLK) disable iff (!RST_N)
         CE && !wr_mask |=> $stable(interrupt_mask_register);
   endproperty
   a_mask_holds: assert property (p_mask_holds) else $error("mask changed unwritten"); // [R1]

   property p_raw_sticky;
      @(posedge CLK) disable iff (!RST_N)
         CE && event_vec == {N{1'b0}} && !wr_misc |=> $stable(raw_event_status_register);
   endproperty
   a_raw_sticky: assert property (p_raw_sticky) else $error("raw bit changed alone"); // [R10]

   // A low clock enable must hold the interrupt, the raw status and the mask register
   property p_freeze;
      @(posedge CLK) disable iff (!RST_N)
         !CE |=> $stable(IRQ) && $stable(raw_event_status_register)
                 && $stable(interrupt_mask_register);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // [R13]

   property p_bo_quiet;
      @(posedge CLK) disable iff (!RST_N)
         CE && brownout_irq_or_reset_select
            && (raw_event_status_register & interrupt_mask_register) == BO_ONLY |=> !IRQ;
   endproperty
   a_bo_quiet: assert property (p_bo_quiet) else $error("brownout irq not gated"); // [R12]

   property p_fault_to_irq;
      @(posedge CLK) disable iff (!RST_N)
         s_fault_event ##1 (CE && interrupt_mask_register[SIMSK_BIT_PLL_FAULT]) |=> IRQ;
   endproperty
   a_fault_to_irq: assert property (p_fault_to_irq) else $error("fault event lost"); // [R9]
endmodule

// file: bench/simsk_evt_model.sv
/*
 Event source model: turns one-cycle requests from the bench into event pulses.
 Assumes requests are driven just after a rising edge of clk.
*/
`timescale 1ns/1ps
module simsk_evt_model (
   input  wire logic       clk,
   input  wire logic [6:0] fire,
   output logic      [6:0] ev
);
   // Registered so each event is seen by the block a full cycle after the request
   always_ff @(posedge clk) begin
      ev <= fire;
   end
endmodule

// file: bench/tb.sv
/*
 Self-checking bench for the interrupt mask block: AHB-Lite register access,
 event pulses from the event model, mask, clear and brown-out gating.
 Assumes one bus master, HREADY looped from HREADYOUT, CE driven by the bench.
*/
`timescale 1ns/1ps
module tb import simsk_pkg::*;;
   logic        clk, rst_n, ce, hsel, hwrite, hreadyout, hresp, irq;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, rd;
   logic [6:0]  fire, ev;
   int          errors, n_tests;

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   simsk_top dut_u (.CLK(clk), .RST_N(rst_n), .CE(ce), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PLL_LOCK_EVENT(ev[6]),
      .CURRENT_LIMIT_EVENT(ev[5]), .INT_OSC_FAULT_EVENT(ev[4]), .MAIN_OSC_FAULT_EVENT(ev[3]),
      .SUPPLY_UNREG_EVENT(ev[2]), .BROWNOUT_EVENT(ev[1]), .PLL_FAULT_EVENT(ev[0]), .IRQ(irq));
   simsk_evt_model evt_u (.clk(clk), .fire(fire), .ev(ev));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Master holds each phase until hready is seen high at a rising edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= SIMSK_HTRANS_NONSEQ;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      fire <= 7'h01 << i;
      @(posedge clk);
      fire <= 7'h00;
      repeat (3) @(posedge clk);
   endtask

   task automatic irq_is(input logic exp);
      @(posedge clk);
      #1;
      check("irq", {31'h0, irq}, {31'h0, exp});
   endtask

   task automatic t_regs();
      bus(1'b0, SIMSK_MASK_OFFSET, 32'h0);
      check("mask reset", rd, 32'h00000000);
      check("hresp", {31'h0, hresp}, 32'h00000000);
      check("hreadyout", {31'h0, hreadyout}, 32'h00000001);
      bus(1'b1, SIMSK_MASK_OFFSET, 32'hFFFFFFFF);
      bus(1'b0, SIMSK_MASK_OFFSET, 32'h0);
      check("mask all ones", rd, 32'h0000007F);
      bus(1'b1, SIMSK_MASK_OFFSET, 32'h00000055);
      bus(1'b0, SIMSK_MASK_OFFSET, 32'h0);
      check("mask pattern", rd, 32'h00000055);
      bus(1'b0, 12'h100, 32'h0);
      check("unmapped read", rd, 32'h00000000);
      bus(1'b1, SIMSK_MASK_OFFSET, 32'h0);
   endtask

   // Each event in turn: raw sets unmasked, then mask raises irq, W1C drops it
   task automatic t_events();
      logic [31:0] b;
      for (int i = 0; i < SIMSK_NUM_EVENTS; i++) begin
         b = 32'h1 << i;
         pulse(i);
         bus(1'b0, SIMSK_RAW_OFFSET, 32'h0);
         check("raw set", rd, b);
         irq_is(1'b0);
         bus(1'b1, SIMSK_MASK_OFFSET, b);
         irq_is(1'b1);
         bus(1'b0, SIMSK_MISC_OFFSET, 32'h0);
         check("masked status", rd, b);
         bus(1'b1, SIMSK_MISC_OFFSET, b);
         irq_is(1'b0);
         bus(1'b0, SIMSK_RAW_OFFSET, 32'h0);
         check("raw cleared", rd, 32'h0);
         bus(1'b1, SIMSK_MASK_OFFSET, 32'h0);
      end
   endtask

   task automatic t_brownout();
      bus(1'b1, SIMSK_BOCTL_OFFSET, 32'h00000002);
      bus(1'b1, SIMSK_MASK_OFFSET, 32'h00000002);
      pulse(SIMSK_BIT_BROWNOUT);
      irq_is(1'b0);
      bus(1'b0, SIMSK_MISC_OFFSET, 32'h0);
      check("brownout gated", rd, 32'h0);
      bus(1'b1, SIMSK_BOCTL_OFFSET, 32'h0);
      irq_is(1'b1);
      bus(1'b1, SIMSK_MISC_OFFSET, 32'h00000002);
      irq_is(1'b0);
   endtask

   // Clock enable low must freeze events, bus writes and the interrupt
   task automatic t_freeze();
      bus(1'b1, SIMSK_MASK_OFFSET, 32'h00000001);
      @(posedge clk);
      ce <= 1'b0;
      pulse(SIMSK_BIT_PLL_FAULT);
      ce <= 1'b1;
      irq_is(1'b0);
      bus(1'b0, SIMSK_RAW_OFFSET, 32'h0);
      check("raw frozen", rd, 32'h00000000);
      pulse(SIMSK_BIT_PLL_FAULT);
      @(posedge clk);
      ce <= 1'b0;
      bus(1'b1, SIMSK_MISC_OFFSET, 32'h00000001);
      irq_is(1'b1);
      @(posedge clk);
      ce <= 1'b1;
      bus(1'b0, SIMSK_RAW_OFFSET, 32'h0);
      check("clear frozen", rd, 32'h00000001);
      bus(1'b1, SIMSK_MISC_OFFSET, 32'h00000001);
      bus(1'b1, SIMSK_MASK_OFFSET, 32'h0);
   endtask

   // Reset in mid-run must drop a live mask and interrupt
   task automatic t_rerst();
      bus(1'b1, SIMSK_MASK_OFFSET, 32'h0000007F);
      pulse(SIMSK_BIT_PLL_LOCK);
      irq_is(1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      irq_is(1'b0);
      bus(1'b0, SIMSK_MASK_OFFSET, 32'h0);
      check("mask after reset", rd, 32'h0);
      bus(1'b0, SIMSK_RAW_OFFSET, 32'h0);
      check("raw after reset", rd, 32'h0);
   endtask

   initial begin
      errors = 0;
      n_tests = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwdata = 32'h0;
      fire = 7'h00;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_events();
      t_brownout();
      t_freeze();
      t_rerst();
      complete_run();
   end

   // The whole run needs well under a thousand cycles
   initial begin
      #20000;
      errors++;
      complete_run();
   end
endmodule
